// ===== include/sdc_pkg.sv
// Constants and types shared by the spindle drive control interface
package sdc_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	// Input filter: a change must stand this long before it is acted on
	localparam int unsigned FILT_NS = 100;
	localparam int unsigned FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned FILT_W = 8;
	// Quadrature rates
	localparam int unsigned ENC_NOM_HZ = 5_000_000;
	localparam int unsigned ENC_MAX_HZ = 10_000_000;
	// Wye/delta change allowed only below this speed, rpm
	localparam logic [15:0] WYE_DELTA_RPM = 16'h0032;
	// Load meter: 16-bit code over -10 V .. +10 V, mV per full scale
	localparam int unsigned LOAD_FS_MV = 10_000;
	localparam int unsigned LOAD_100_MV = 2_500;
	localparam int unsigned LOAD_150_MV = 3_750;
	localparam logic [15:0] LOAD_ZERO = 16'h8000;
	// 100% current code = 0x8000 * 2500 / 10000 = 0x2000 above zero
	localparam logic [15:0] LOAD_100_STEP = 16'h2000;
	// Display segment bits {g,f,e,d,c,b,a}
	localparam logic [6:0] SEG_A = 7'h01;
	localparam logic [6:0] SEG_F = 7'h20;
	localparam logic [6:0] SEG_OFF = 7'h00;
	localparam logic [6:0] CHR_FAULT = 7'h71;
	localparam logic [6:0] CHR_ESTOP = 7'h79;
	localparam logic [6:0] CHR_CLAMP = 7'h40;
	localparam logic [2:0] COMM_LAST = 3'h5;
	typedef enum logic [4:0] {
		SDC_OFF = 5'h01,
		SDC_CCW = 5'h02,
		SDC_CW = 5'h04,
		SDC_TAP = 5'h08,
		SDC_STOP = 5'h10
	} sdc_mode_t;
endpackage

// ===== rtl/sdc_filter.sv
// Two-flop synchroniser plus stability filter for one external level
`timescale 1ns/1ps
module sdc_filter
	import sdc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic raw,
	output logic filt
);
	logic meta;
	logic sync;
	logic [FILT_W-1:0] cnt;
	logic [FILT_W-1:0] next_cnt;
	logic next_filt;

	always_comb
	begin
		next_cnt = cnt;
		next_filt = filt;
		if (sync == filt)
			next_cnt = '0;
		else if (cnt == FILT_W'(FILT_CYC - 1))
		begin
			next_filt = sync;
			next_cnt = '0;
		end
		else
			next_cnt = cnt + FILT_W'(1);
	end

	// Resets to high: a floating active-low line counts as released
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta <= 1'b1;
			sync <= 1'b1;
			cnt <= '0;
			filt <= 1'b1;
		end
		else
		begin
			meta <= raw;
			sync <= meta;
			cnt <= next_cnt;
			filt <= next_filt;
		end
	end
endmodule

// ===== rtl/sdc_top.sv
// Spindle drive control interface: enable decode, interlocks, display, encoder copy, load meter
`timescale 1ns/1ps
//
// Overview of operation
// - In normal run exactly one of six outer display segments is lit.
// - Lit segment steps once per commutation state, six per pole pair.
// - Clamped current or fault replaces commutation with a state character.
// - Forward enable alone runs counter-clockwise with unipolar speed.
// - CW enable alone runs clockwise with unipolar speed.
// - Both enables select rigid tap with signed speed; one selects non-rigid.
// - Both enables released turns drive off, no voltage or flux.
// - Going from enabled to both released is a stop; decelerate actively.
// - Wye/delta change only when off and speed below threshold.
// - Winding select low requests delta, released requests wye.
// - Gain select low requests low gain, released high gain.
// - Emergency stop ignores enables and speed, ramps motor to a stop.
// - Fault pulls shared line low through open collector output.
// - Speed is non-negative in non-rigid tap, signed in rigid tap.
// - Index edge detected regardless of polarity of its wires.
// - Encoder inputs accept nominal quadrature rate, tolerate higher rate.
// - A and B channels copied unaltered to buffered outputs; index copy held low.
// - Load value 16-bit, 100% current at 2.5 V, 150% at 3.75 V.
// - Drive enable commands arrive over the host port, taken when host_cmd_valid is high.
module sdc_top
	import sdc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ccw_run_enable_n,
	input wire logic cw_run_enable_n,
	input wire logic winding_config_select_n,
	input wire logic gain_select_n,
	input wire logic shared_stop_fault_line_in,
	output logic shared_stop_fault_line_out,
	output logic shared_stop_fault_line_oe_n,
	input wire logic drive_fault_flag,
	input wire logic current_clamped,
	input wire logic motor_stopped,
	input wire logic [15:0] motor_speed_rpm,
	input wire logic [15:0] speed_command,
	input wire logic comm_step,
	input wire logic [15:0] motor_current_pct,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_z,
	input wire logic host_cmd_valid,
	input wire logic host_drive_enable,
	output logic drive_on,
	output logic dir_cw,
	output logic rigid_tap,
	output logic decel_request,
	output logic delta_mode,
	output logic low_gain,
	output logic [15:0] speed_ref,
	output logic [6:0] status_segments,
	output logic encoder_a_copy,
	output logic encoder_b_copy,
	output logic encoder_index_copy,
	output logic index_event,
	output logic [15:0] load_meter_code
);
	logic ccw_f;
	logic cw_f;
	logic wye_f;
	logic gain_f;
	logic estop_f;
	logic [1:0] a_s;
	logic [1:0] b_s;
	logic [1:0] z_s;
	logic z_last;
	logic host_en;
	sdc_mode_t mode;
	sdc_mode_t next_mode;
	logic [2:0] comm;
	logic [2:0] next_comm;
	logic next_delta;
	logic next_low_gain;
	logic [15:0] next_speed_ref;
	logic [6:0] next_segments;
	logic [15:0] next_load;
	logic next_fault_drive;

	// Controller lines and the shared stop line, each synchronised and filtered
	sdc_filter u_f_ccw (.mclk(mclk), .sys_rst(sys_rst), .raw(ccw_run_enable_n), .filt(ccw_f));
	sdc_filter u_f_cw (.mclk(mclk), .sys_rst(sys_rst), .raw(cw_run_enable_n), .filt(cw_f));
	sdc_filter u_f_wye (.mclk(mclk), .sys_rst(sys_rst), .raw(winding_config_select_n), .filt(wye_f));
	sdc_filter u_f_gain (.mclk(mclk), .sys_rst(sys_rst), .raw(gain_select_n), .filt(gain_f));
	sdc_filter u_f_est (.mclk(mclk), .sys_rst(sys_rst), .raw(shared_stop_fault_line_in),
		.filt(estop_f));

	// Segment for commutation state 0..5, a through f
	function automatic logic [6:0] comm_seg(input logic [2:0] s);
		comm_seg = SEG_A << s;
	endfunction

	function automatic logic any_enable(input logic ccw_n, input logic cw_n);
		any_enable = !ccw_n || !cw_n;
	endfunction

	// Own line pulled low by us reads as low too; only an outside low is an estop
	logic estop_req;
	assign estop_req = !estop_f && shared_stop_fault_line_oe_n;

	always_comb
	begin
		next_mode = mode;
		if (estop_req)
			// Once the ramp has brought the motor to rest the drive drops to off
			next_mode = (mode == SDC_OFF || motor_stopped) ? SDC_OFF : SDC_STOP;
		else if (!ccw_f && !cw_f && host_en)
			next_mode = SDC_TAP;
		else if (!ccw_f && host_en)
			next_mode = SDC_CCW;
		else if (!cw_f && host_en)
			next_mode = SDC_CW;
		else if (mode != SDC_OFF && !motor_stopped)
			next_mode = SDC_STOP;
		else
			next_mode = SDC_OFF;
	end

	always_comb
	begin
		next_speed_ref = 16'h0000;
		unique case (next_mode)
			SDC_TAP: next_speed_ref = speed_command;
			SDC_CCW, SDC_CW: next_speed_ref = speed_command[15] ? 16'h0000 : speed_command;
			SDC_OFF, SDC_STOP: next_speed_ref = 16'h0000;
		endcase
	end

	// Winding change only while off and slow
	always_comb
	begin
		next_delta = delta_mode;
		if (mode == SDC_OFF && ccw_f && cw_f && motor_speed_rpm < WYE_DELTA_RPM)
			next_delta = !wye_f;
		next_low_gain = !gain_f;
	end

	always_comb
	begin
		next_comm = comm;
		if (comm_step)
			next_comm = (comm == COMM_LAST) ? 3'h0 : comm + 3'h1;
		next_fault_drive = drive_fault_flag;
		if (drive_fault_flag)
			next_segments = CHR_FAULT;
		else if (estop_req)
			next_segments = CHR_ESTOP;
		else if (current_clamped || next_mode == SDC_OFF)
			next_segments = CHR_CLAMP;
		else
			next_segments = comm_seg(next_comm);
		// Offset-binary code: 0x8000 is 0 V, 0x2000 per 100% current
		if (motor_current_pct > 16'h0190)
			next_load = 16'hFFFF;
		else
			next_load = LOAD_ZERO + 16'((32'(motor_current_pct) * 32'(LOAD_100_STEP)) / 32'h64);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode <= SDC_OFF;
			comm <= 3'h0;
			host_en <= 1'b1;
			drive_on <= 1'b0;
			dir_cw <= 1'b0;
			rigid_tap <= 1'b0;
			decel_request <= 1'b0;
			delta_mode <= 1'b0;
			low_gain <= 1'b0;
			speed_ref <= 16'h0000;
			status_segments <= CHR_CLAMP;
			shared_stop_fault_line_out <= 1'b0;
			shared_stop_fault_line_oe_n <= 1'b1;
			a_s <= 2'b00;
			b_s <= 2'b00;
			z_s <= 2'b00;
			z_last <= 1'b0;
			encoder_a_copy <= 1'b0;
			encoder_b_copy <= 1'b0;
			encoder_index_copy <= 1'b0;
			index_event <= 1'b0;
			load_meter_code <= LOAD_ZERO;
		end
		else
		begin
			if (host_cmd_valid)
				host_en <= host_drive_enable;
			mode <= next_mode;
			comm <= next_comm;
			drive_on <= next_mode != SDC_OFF;
			dir_cw <= next_mode == SDC_CW;
			rigid_tap <= next_mode == SDC_TAP;
			decel_request <= next_mode == SDC_STOP;
			delta_mode <= next_delta;
			low_gain <= next_low_gain;
			speed_ref <= next_speed_ref;
			status_segments <= next_segments;
			shared_stop_fault_line_oe_n <= !next_fault_drive;
			// 200 MHz sampling covers 10 MHz quadrature with margin
			a_s <= {a_s[0], enc_a};
			b_s <= {b_s[0], enc_b};
			z_s <= {z_s[0], enc_z};
			z_last <= z_s[1];
			encoder_a_copy <= a_s[1];
			encoder_b_copy <= b_s[1];
			index_event <= z_s[1] ^ z_last;
			load_meter_code <= next_load;
		end
	end

	onehot_seg_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(!drive_fault_flag && !estop_req && !current_clamped && next_mode != SDC_OFF)
		|=> $onehot(status_segments) && status_segments[6] == 1'b0)
		else $error("run display not a single outer segment");
	comm_wrap_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(comm_step && comm == COMM_LAST) |=> comm == 3'h0)
		else $error("commutation did not wrap");
	fault_char_a: assert property (@(posedge mclk) disable iff (sys_rst)
		drive_fault_flag |=> status_segments == CHR_FAULT)
		else $error("fault character missing");
	ccw_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(!ccw_f && cw_f && !estop_req && host_en) |=> drive_on && !dir_cw && !rigid_tap)
		else $error("ccw decode wrong");
	cw_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(ccw_f && !cw_f && !estop_req && host_en) |=> drive_on && dir_cw)
		else $error("cw decode wrong");
	tap_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(!ccw_f && !cw_f && !estop_req && host_en) |=> rigid_tap && speed_ref == $past(speed_command))
		else $error("rigid tap decode wrong");
	stop_decel_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(mode != SDC_OFF && ccw_f && cw_f && !motor_stopped) |=> decel_request)
		else $error("release did not decelerate");
	wye_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(mode != SDC_OFF) |=> $stable(delta_mode))
		else $error("winding changed while running");
	estop_ignore_a: assert property (@(posedge mclk) disable iff (sys_rst)
		estop_req |=> speed_ref == 16'h0000 && !rigid_tap)
		else $error("estop did not override");
	fault_pull_a: assert property (@(posedge mclk) disable iff (sys_rst)
		drive_fault_flag |=> !shared_stop_fault_line_oe_n && !shared_stop_fault_line_out)
		else $error("fault line not pulled low");
	unipolar_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(!rigid_tap && drive_on) |-> !speed_ref[15])
		else $error("negative speed in unipolar mode");
	enc_copy_a: assert property (@(posedge mclk) disable iff (sys_rst)
		##3 encoder_a_copy == $past(enc_a, 3))
		else $error("encoder copy mismatch");
	load_full_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(motor_current_pct == 16'h0064) |=> load_meter_code == 16'hA000)
		else $error("load scale wrong");

	tap_c: cover property (@(posedge mclk) disable iff (sys_rst) rigid_tap);
	stop_c: cover property (@(posedge mclk) disable iff (sys_rst) decel_request ##1 !drive_on);
	delta_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(delta_mode));
	index_c: cover property (@(posedge mclk) disable iff (sys_rst) index_event);
endmodule

// ===== testbench/sdc_cnc_model.sv
// Controller model: active-low lines that float up to their pull-ups when released
`timescale 1ns/1ps
module sdc_cnc_model
(
	input wire logic run_ccw,
	input wire logic run_cw,
	input wire logic want_delta,
	input wire logic want_low_gain,
	input wire logic estop,
	input wire logic dut_line_out,
	input wire logic dut_line_oe_n,
	output logic ccw_n,
	output logic cw_n,
	output logic winding_n,
	output logic gain_n,
	output logic stop_line
);
	assign ccw_n = ~run_ccw;
	assign cw_n = ~run_cw;
	assign winding_n = ~want_delta;
	assign gain_n = ~want_low_gain;
	// Wired-AND: either party may sink it, otherwise the pull-up wins
	assign stop_line = ~estop & (dut_line_oe_n | dut_line_out);
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the spindle drive control interface
`timescale 1ns/1ps
module tb_top;
	import sdc_pkg::*;
	typedef struct packed {logic ccw; logic cw; logic [15:0] cmd; logic on; logic dir;
		logic rig; logic [15:0] ref_v;} sdc_row_t;
	logic mclk, sys_rst, run_ccw, run_cw, want_delta, want_low_gain, estop;
	logic ccw_n, cw_n, winding_n, gain_n, stop_line, line_out, line_oe_n;
	logic drive_fault_flag, current_clamped, motor_stopped, comm_step;
	logic [15:0] motor_speed_rpm, speed_command, motor_current_pct, speed_ref, load_meter_code;
	logic enc_a, enc_b, enc_z, host_cmd_valid, host_drive_enable;
	logic drive_on, dir_cw, rigid_tap, decel_request, delta_mode, low_gain;
	logic [6:0] status_segments, seg0, segp;
	logic a_copy, b_copy, z_copy, index_event;
	int n_errors, checks, i, k, n;
	sdc_row_t rows [5] = '{
		{1'h1, 1'h0, 16'h1000, 1'h1, 1'h0, 1'h0, 16'h1000},
		{1'h0, 1'h1, 16'h1000, 1'h1, 1'h1, 1'h0, 16'h1000},
		{1'h0, 1'h1, 16'hF000, 1'h1, 1'h1, 1'h0, 16'h0000},
		{1'h1, 1'h1, 16'hF000, 1'h1, 1'h0, 1'h1, 16'hF000},
		{1'h1, 1'h0, 16'h7FFF, 1'h1, 1'h0, 1'h0, 16'h7FFF}};
	logic [15:0] pct [3] = '{16'h0000, 16'h0064, 16'h0096};
	logic [15:0] lexp [3] = '{16'h8000, 16'hA000, 16'hB000};

	sdc_cnc_model u_cnc (.run_ccw(run_ccw), .run_cw(run_cw), .want_delta(want_delta),
		.want_low_gain(want_low_gain), .estop(estop), .dut_line_out(line_out),
		.dut_line_oe_n(line_oe_n), .ccw_n(ccw_n), .cw_n(cw_n), .winding_n(winding_n),
		.gain_n(gain_n), .stop_line(stop_line));
	sdc_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .ccw_run_enable_n(ccw_n),
		.cw_run_enable_n(cw_n), .winding_config_select_n(winding_n), .gain_select_n(gain_n),
		.shared_stop_fault_line_in(stop_line), .shared_stop_fault_line_out(line_out),
		.shared_stop_fault_line_oe_n(line_oe_n), .drive_fault_flag(drive_fault_flag),
		.current_clamped(current_clamped), .motor_stopped(motor_stopped),
		.motor_speed_rpm(motor_speed_rpm), .speed_command(speed_command),
		.comm_step(comm_step), .motor_current_pct(motor_current_pct), .enc_a(enc_a),
		.enc_b(enc_b), .enc_z(enc_z), .host_cmd_valid(host_cmd_valid),
		.host_drive_enable(host_drive_enable), .drive_on(drive_on), .dir_cw(dir_cw),
		.rigid_tap(rigid_tap), .decel_request(decel_request), .delta_mode(delta_mode),
		.low_gain(low_gain), .speed_ref(speed_ref), .status_segments(status_segments),
		.encoder_a_copy(a_copy), .encoder_b_copy(b_copy), .encoder_index_copy(z_copy),
		.index_event(index_event), .load_meter_code(load_meter_code));

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Outputs are read mid-cycle so they never race the launching edge
	task automatic step(input int c);
		repeat (c) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		complete_run();
	end
	initial
	begin
		{run_ccw, run_cw, want_delta, want_low_gain, estop, drive_fault_flag} = 6'h00;
		{current_clamped, comm_step, enc_a, enc_b, enc_z, host_cmd_valid} = 6'h00;
		motor_stopped = 1'h1;
		host_drive_enable = 1'h1;
		{motor_speed_rpm, speed_command, motor_current_pct} = 48'h0;
		sys_rst = 1'h1;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'h0;
		for (i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			run_ccw <= rows[i].ccw;
			run_cw <= rows[i].cw;
			speed_command <= rows[i].cmd;
			step(30);
			chk_bit("drive_on", rows[i].on, drive_on);
			if (!rows[i].rig)
				chk_bit("dir_cw", rows[i].dir, dir_cw);
			chk_bit("rigid_tap", rows[i].rig, rigid_tap);
			chk_word("speed_ref", rows[i].ref_v, speed_ref);
			$display("Row %0d done", i);
		end
		seg0 = status_segments;
		for (k = 0; k < 12; k++)
		begin
			segp = status_segments;
			@(posedge mclk);
			comm_step <= 1'h1;
			@(posedge mclk);
			comm_step <= 1'h0;
			step(2);
			chk_bit("one_hot", 1'h1, $onehot(status_segments[5:0]) && !status_segments[6]);
			chk_bit("advance", 1'h1, status_segments !== segp);
			if (k == 5 || k == 11)
				chk_word("segments", {9'h0, seg0}, {9'h0, status_segments});
		end
		@(posedge mclk);
		current_clamped <= 1'h1;
		step(3);
		chk_word("segments", {9'h0, CHR_CLAMP}, {9'h0, status_segments});
		$display("Display test done");
		@(posedge mclk);
		current_clamped <= 1'h0;
		motor_stopped <= 1'h0;
		estop <= 1'h1;
		step(30);
		chk_bit("decel_request", 1'h1, decel_request);
		chk_word("segments", {9'h0, CHR_ESTOP}, {9'h0, status_segments});
		@(posedge mclk);
		run_ccw <= 1'h0;
		run_cw <= 1'h1;
		motor_stopped <= 1'h1;
		step(30);
		chk_bit("drive_on", 1'h0, drive_on);
		@(posedge mclk);
		run_cw <= 1'h0;
		estop <= 1'h0;
		step(30);
		@(posedge mclk);
		run_ccw <= 1'h1;
		step(30);
		chk_bit("drive_on", 1'h1, drive_on);
		@(posedge mclk);
		motor_stopped <= 1'h0;
		run_ccw <= 1'h0;
		step(30);
		chk_bit("decel_request", 1'h1, decel_request);
		@(posedge mclk);
		motor_stopped <= 1'h1;
		step(5);
		chk_bit("decel_request", 1'h0, decel_request);
		chk_bit("drive_on", 1'h0, drive_on);
		$display("Stop tests done");
		@(posedge mclk);
		want_delta <= 1'h1;
		step(30);
		chk_bit("delta_mode", 1'h1, delta_mode);
		@(posedge mclk);
		run_cw <= 1'h1;
		step(30);
		@(posedge mclk);
		want_delta <= 1'h0;
		step(30);
		chk_bit("delta_mode", 1'h1, delta_mode);
		@(posedge mclk);
		run_cw <= 1'h0;
		motor_speed_rpm <= 16'h0064;
		step(30);
		chk_bit("delta_mode", 1'h1, delta_mode);
		@(posedge mclk);
		motor_speed_rpm <= 16'h0000;
		step(5);
		chk_bit("delta_mode", 1'h0, delta_mode);
		for (k = 0; k < 2; k++)
		begin
			@(posedge mclk);
			want_low_gain <= !k[0];
			step(30);
			chk_bit("low_gain", !k[0], low_gain);
		end
		@(posedge mclk);
		drive_fault_flag <= 1'h1;
		step(3);
		chk_bit("line_oe_n", 1'h0, line_oe_n);
		chk_bit("stop_line", 1'h0, stop_line);
		chk_word("segments", {9'h0, CHR_FAULT}, {9'h0, status_segments});
		@(posedge mclk);
		drive_fault_flag <= 1'h0;
		host_drive_enable <= 1'h0;
		host_cmd_valid <= 1'h1;
		@(posedge mclk);
		host_cmd_valid <= 1'h0;
		run_ccw <= 1'h1;
		step(30);
		chk_bit("drive_on", 1'h0, drive_on);
		@(posedge mclk);
		host_drive_enable <= 1'h1;
		host_cmd_valid <= 1'h1;
		@(posedge mclk);
		host_cmd_valid <= 1'h0;
		step(5);
		chk_bit("drive_on", 1'h1, drive_on);
		$display("Mode and fault tests done");
		for (k = 0; k < 4; k++)
		begin
			@(posedge mclk);
			enc_a <= k[0];
			enc_b <= k[1];
			enc_z <= !enc_z;
			n = 0;
			repeat (8)
			begin
				@(negedge mclk);
				if (index_event === 1'h1)
					n++;
			end
			chk_bit("a_copy", k[0], a_copy);
			chk_bit("b_copy", k[1], b_copy);
			chk_bit("z_copy", 1'h0, z_copy);
			chk_word("index pulses", 16'h0001, n[15:0]);
		end
		for (k = 0; k < 3; k++)
		begin
			@(posedge mclk);
			motor_current_pct <= pct[k];
			step(3);
			chk_word("load_meter_code", lexp[k], load_meter_code);
		end
		$display("Encoder and load tests done");
		complete_run();
	end
endmodule
